// ==== shared/seq_pkg.sv ====
// Constants, register map and state codes for the motor start sequencer.
// Assumes a 200 MHz system clock and a 32-bit APB register bus.
`default_nettype none
package seq_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_PERIOD_MS = 1;
	localparam int TICK_PERIOD_NS = TICK_PERIOD_MS * 1000000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int FAULT_WAIT_S = 10;
	localparam int FAULT_WAIT_TICKS = FAULT_WAIT_S * 1000 / TICK_PERIOD_MS;
	localparam int CNT_W = 32;
	// ==========================================================
	// Register map, byte addresses
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] FAULT_ACK_ADDR = 8'h04;
	localparam logic [7:0] STATUS_ADDR = 8'h08;
	localparam logic [7:0] CFG_BASE_ADDR = 8'h0c;
	localparam int CFG_NUM = 6;
	localparam int CFG_W = 16;
	// Config word indices from CFG_BASE_ADDR
	localparam int CFG_CATCH = 0;
	localparam int CFG_ALIGN = 1;
	localparam int CFG_ACCEL = 2;
	localparam int CFG_SENSE = 3;
	localparam int CFG_THR = 4;
	localparam int CFG_MINIMUM_CLOSED_LOOP_SPEED = 5;
	localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;
	// CTRL fields
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam int CTRL_SERIAL_BIT = 2;
	localparam int FACK_BIT = 0;
	// STATUS fields
	localparam int STAT_OFFS_BIT = 4;
	localparam int STAT_FAULT_BIT = 5;
	// ==========================================================
	// Latched events
	localparam int EV_START = 0;
	localparam int EV_STOP = 1;
	localparam int EV_FACK = 2;
	localparam int EV_CAL = 3;
	localparam int EV_CHG = 4;
	localparam int EV_SENSE = 5;
	localparam int EV_NUM = 6;
	// ==========================================================
	// Sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_STOP = 4'b0001,
		ST_OFFSET_CAL = 4'b0010,
		ST_PRECHARGE = 4'b0011,
		ST_RUN = 4'b0100,
		ST_FAULT = 4'b0101,
		ST_CATCH = 4'b0110,
		ST_PARK = 4'b0111,
		ST_FORCED = 4'b1000,
		ST_ANGLE = 4'b1001
	} seq_state_t;
endpackage : seq_pkg
`default_nettype wire

// ==== shared/seq_if.sv ====
// Carrier between the sequencer and its tick and fault-timer helpers.
// Assumes all parties share clk and rst.
`default_nettype none
interface seq_if;
	logic tick;
	logic fault_hold;
	logic fault_timeout;
	modport tick_src (output tick);
	modport timer (input tick, input fault_hold, output fault_timeout);
	modport seq (input tick, output fault_hold, input fault_timeout);
endinterface : seq_if
`default_nettype wire

// ==== hdl/tick_gen.sv ====
// Periodic sequencer tick, one clock wide.
// Assumes a free-running clock; period set by the parent.
`default_nettype none
module tick_gen
	import seq_pkg::*;
#(
	parameter int PERIOD = TICK_CYCLES
)
(
	input wire logic clk,
	input wire logic rst,
	seq_if.tick_src sif
);
	logic [CNT_W-1:0] cnt_r;
	// ==========================================================
	// Divider
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_r <= '0;
			sif.tick <= 1'b0;
		end
		else if (cnt_r == CNT_W'(PERIOD - 1))
		begin
			cnt_r <= '0;
			sif.tick <= 1'b1;
		end
		else
		begin
			cnt_r <= cnt_r + 1'b1;
			sif.tick <= 1'b0;
		end
	end
endmodule : tick_gen
`default_nettype wire

// ==== hdl/fault_timer.sv ====
// Counts ticks spent in the fault state and flags the automatic exit.
// Assumes fault_hold drops as soon as the sequencer leaves fault.
`default_nettype none
module fault_timer
	import seq_pkg::*;
#(
	parameter int WAIT_TICKS = FAULT_WAIT_TICKS
)
(
	input wire logic clk,
	input wire logic rst,
	seq_if.timer sif
);
	logic [CNT_W-1:0] cnt_r;
	// ==========================================================
	// Tick counter, restarts on every fault entry
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_r <= '0;
		else if (!sif.fault_hold)
			cnt_r <= '0;
		else if (sif.tick && cnt_r != CNT_W'(WAIT_TICKS))
			cnt_r <= cnt_r + 1'b1;
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			sif.fault_timeout <= 1'b0;
		else
			// Raised one count early so the exit lands on the last tick
			sif.fault_timeout <= sif.fault_hold
				&& cnt_r >= CNT_W'(WAIT_TICKS - 1);
	end
endmodule : fault_timer
`default_nettype wire

// ==== hdl/motor_start_sequencer.sv ====
// Ten-state start-up sequencer for a sensorless PM motor drive, APB slave.
// Assumes measurement, estimator and PWM units drive the status inputs
// synchronously to clk and read the enables below.
//
// How it works
// - Evaluate transitions once per 1 ms tick
// - Ten states 0-9, state readable
// - Idle after reset until parameters valid
// - Stop goes to calibration if not done
// - Stop waits start, then pre-charge; measure
// - Calibration state returns to stop when done
// - Pre-charge complete moves to catch
// - Stop command in run returns to stop
// - Any fault enters fault state, motor off
// - Serial mode: fault acknowledge write leaves fault
// - Other modes: leave fault after 10 s
// - Catch runs estimator, currents held zero
// - Catch speed above threshold runs, else sensing
// - Zero catch duration skips to sensing
// - Parking ramps current over align duration
// - Zero align duration leaves parking at once
// - Forced ramp to minimum speed, then run
// - Zero ramp rate goes straight to run
// - Angle sensing done moves to run
// - Zero pulse length goes to parking
`default_nettype none
module motor_start_sequencer
	import seq_pkg::*;
#(
	parameter int TICK_PERIOD = TICK_CYCLES,
	parameter int FAULT_TICKS = FAULT_WAIT_TICKS
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic params_valid,
	input wire logic fault_in,
	input wire logic offset_cal_done,
	input wire logic precharge_done,
	input wire logic sense_done,
	input wire logic signed [15:0] measured_speed,
	output logic [3:0] sequencer_state_var,
	output logic measure_en,
	output logic offset_calibration,
	output logic bootstrap_precharge,
	output logic spinning_rotor_catch,
	output logic align_en,
	output logic forced_angle_ramp,
	output logic initial_angle_detect,
	output logic closed_loop_run,
	output logic current_cmd_zero,
	output logic [15:0] align_step,
	output logic [15:0] forced_speed,
	output logic [15:0] sense_pulse_length
);
	seq_if sif ();
	seq_state_t state_r, state_nxt;
	logic [CFG_W-1:0] cfg_r [CFG_NUM];
	logic [EV_NUM-1:0] ev_r, ev_in;
	logic serial_mode_r;
	logic offs_done_r;
	logic [CFG_W-1:0] elapsed_r;
	logic [CFG_W-1:0] ramp_r;
	logic [CFG_W-1:0] abs_speed;
	logic wr_ok, rd_hit, cfg_hit;
	logic [7:0] cfg_off;
	logic [2:0] cfg_idx;

	tick_gen #(.PERIOD(TICK_PERIOD)) u_tick (
		.clk(clk),
		.rst(rst),
		.sif(sif.tick_src)
	);
	fault_timer #(.WAIT_TICKS(FAULT_TICKS)) u_ftimer (
		.clk(clk),
		.rst(rst),
		.sif(sif.timer)
	);

	// ==========================================================
	// APB slave: one wait state so read data comes from a flop
	assign cfg_off = paddr - CFG_BASE_ADDR;
	assign cfg_idx = cfg_off[4:2];
	assign cfg_hit = paddr >= CFG_BASE_ADDR && paddr[1:0] == 2'b00
		&& cfg_off < 8'(CFG_NUM * 4);
	assign rd_hit = cfg_hit || paddr == CTRL_ADDR
		|| paddr == FAULT_ACK_ADDR || paddr == STATUS_ADDR;
	assign wr_ok = psel && penable && pready && pwrite && !pslverr;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else if (psel && penable && !pready)
		begin
			pready <= 1'b1;
			pslverr <= !rd_hit || (pwrite && paddr == STATUS_ADDR);
			prdata <= '0;
			if (!pwrite && cfg_hit)
				prdata <= {16'h0000, cfg_r[cfg_idx]};
			else if (!pwrite && paddr == CTRL_ADDR)
				prdata <= 32'(serial_mode_r) << CTRL_SERIAL_BIT;
			else if (!pwrite && paddr == STATUS_ADDR)
				prdata <= {26'h0000000, fault_in, offs_done_r,
					state_r};
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			serial_mode_r <= 1'b0;
		else if (wr_ok && paddr == CTRL_ADDR)
			serial_mode_r <= pwdata[CTRL_SERIAL_BIT];
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < CFG_NUM; i++)
				cfg_r[i] <= CFG_RESET;
		end
		else if (wr_ok && cfg_hit)
			cfg_r[cfg_idx] <= pwdata[CFG_W-1:0];
	end

	// ==========================================================
	// Event latches: held until the next tick; a new event wins
	// over the tick's clear so nothing arriving then is lost
	assign ev_in[EV_START] = wr_ok && paddr == CTRL_ADDR
		&& pwdata[CTRL_START_BIT];
	assign ev_in[EV_STOP] = wr_ok && paddr == CTRL_ADDR
		&& pwdata[CTRL_STOP_BIT];
	assign ev_in[EV_FACK] = wr_ok && paddr == FAULT_ACK_ADDR
		&& pwdata[FACK_BIT];
	assign ev_in[EV_CAL] = offset_cal_done;
	assign ev_in[EV_CHG] = precharge_done;
	assign ev_in[EV_SENSE] = sense_done;

	generate
		for (genvar g = 0; g < EV_NUM; g++)
		begin : g_ev
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
					ev_r[g] <= 1'b0;
				else if (ev_in[g])
					ev_r[g] <= 1'b1;
				else if (sif.tick)
					ev_r[g] <= 1'b0;
			end
		end
	endgenerate

	// ==========================================================
	// Transition logic
	assign abs_speed = measured_speed[15] ? 16'(-measured_speed)
		: 16'(measured_speed);

	always_comb
	begin
		state_nxt = state_r;
		if (sif.tick)
		begin
			if (fault_in && state_r != ST_FAULT)
				state_nxt = ST_FAULT;
			else
			begin
				unique case (state_r)
					ST_IDLE:
						if (params_valid)
							state_nxt = ST_STOP;
					ST_STOP:
						if (!offs_done_r)
							state_nxt = ST_OFFSET_CAL;
						else if (ev_r[EV_START])
							state_nxt = ST_PRECHARGE;
					ST_OFFSET_CAL:
						if (ev_r[EV_CAL])
							state_nxt = ST_STOP;
					ST_PRECHARGE:
						if (ev_r[EV_CHG])
							state_nxt = ST_CATCH;
					ST_RUN:
						if (ev_r[EV_STOP])
							state_nxt = ST_STOP;
					ST_FAULT:
						if (serial_mode_r && ev_r[EV_FACK])
							state_nxt = ST_STOP;
						else if (!serial_mode_r && sif.fault_timeout)
							state_nxt = ST_STOP;
					ST_CATCH:
						if (cfg_r[CFG_CATCH] == CFG_RESET)
							state_nxt = ST_ANGLE;
						else if (elapsed_r >= cfg_r[CFG_CATCH])
							state_nxt = abs_speed > cfg_r[CFG_THR]
								? ST_RUN : ST_ANGLE;
					ST_PARK:
						if (elapsed_r >= cfg_r[CFG_ALIGN])
							state_nxt = ST_FORCED;
					ST_FORCED:
						if (cfg_r[CFG_ACCEL] == CFG_RESET)
							state_nxt = ST_RUN;
						else if (ramp_r >= cfg_r[CFG_MINIMUM_CLOSED_LOOP_SPEED])
							state_nxt = ST_RUN;
					ST_ANGLE:
						if (cfg_r[CFG_SENSE] == CFG_RESET)
							state_nxt = ST_PARK;
						else if (ev_r[EV_SENSE])
							state_nxt = ST_RUN;
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Calibration runs once per power-up; stop consults this flag
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			offs_done_r <= 1'b0;
		else if (state_r == ST_OFFSET_CAL && state_nxt == ST_STOP)
			offs_done_r <= 1'b1;
	end

	// ==========================================================
	// Per-state tick counter and forced-angle speed ramp
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			elapsed_r <= '0;
		else if (state_nxt != state_r)
			elapsed_r <= '0;
		else if (sif.tick && elapsed_r != 16'hffff)
			elapsed_r <= elapsed_r + 1'b1;
	end

	// Saturating add avoids a wrap that would never reach the target
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ramp_r <= '0;
		else if (state_r != ST_FORCED)
			ramp_r <= '0;
		else if (sif.tick)
			ramp_r <= (17'(ramp_r) + 17'(cfg_r[CFG_ACCEL])) > 17'h0ffff
				? 16'hffff : ramp_r + cfg_r[CFG_ACCEL];
	end

	assign sif.fault_hold = state_r == ST_FAULT;

	// ==========================================================
	// Registered outputs; state and enables decoded from the next state
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sequencer_state_var <= ST_IDLE;
			measure_en <= 1'b0;
			offset_calibration <= 1'b0;
			bootstrap_precharge <= 1'b0;
			spinning_rotor_catch <= 1'b0;
			align_en <= 1'b0;
			forced_angle_ramp <= 1'b0;
			initial_angle_detect <= 1'b0;
			closed_loop_run <= 1'b0;
			current_cmd_zero <= 1'b1;
			align_step <= '0;
			forced_speed <= '0;
			sense_pulse_length <= '0;
		end
		else
		begin
			sequencer_state_var <= state_nxt;
			measure_en <= state_nxt != ST_IDLE;
			offset_calibration <= state_nxt == ST_OFFSET_CAL;
			bootstrap_precharge <= state_nxt == ST_PRECHARGE;
			spinning_rotor_catch <= state_nxt == ST_CATCH;
			align_en <= state_nxt == ST_PARK;
			forced_angle_ramp <= state_nxt == ST_FORCED;
			initial_angle_detect <= state_nxt == ST_ANGLE;
			closed_loop_run <= state_nxt == ST_RUN;
			current_cmd_zero <= state_nxt != ST_RUN
				&& state_nxt != ST_PARK && state_nxt != ST_FORCED
				&& state_nxt != ST_ANGLE;
			align_step <= state_r == ST_PARK ? elapsed_r : '0;
			forced_speed <= ramp_r;
			sense_pulse_length <= cfg_r[CFG_SENSE];
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	state_tick_a: assert property ($changed(state_r) |-> $past(sif.tick))
		else $error("state moved without a tick");
	state_range_a: assert property (state_r <= ST_ANGLE)
		else $error("state code out of range");
	idle_hold_a: assert property (state_r == ST_IDLE && !params_valid
		&& !fault_in |=> state_r == ST_IDLE)
		else $error("left idle without parameters");
	fault_entry_a: assert property (sif.tick && fault_in
		&& state_r != ST_FAULT |=> state_r == ST_FAULT)
		else $error("fault not entered");
	fault_first_a: assert property (sif.tick && fault_in
		&& state_r == ST_STOP && ev_r[EV_START]
		|=> state_r == ST_FAULT)
		else $error("fault lost priority");
	serial_exit_a: assert property (state_r == ST_FAULT
		&& $past(state_r) == ST_FAULT && serial_mode_r
		|-> state_nxt != ST_STOP || ev_r[EV_FACK])
		else $error("serial fault exit without acknowledge");
	run_stop_a: assert property (sif.tick && state_r == ST_RUN
		&& ev_r[EV_STOP] && !fault_in |=> state_r == ST_STOP)
		else $error("stop command ignored in run");
	catch_zero_a: assert property (sif.tick && state_r == ST_CATCH
		&& !fault_in && cfg_r[CFG_CATCH] == CFG_RESET
		|=> state_r == ST_ANGLE)
		else $error("zero catch duration not skipped");
	sense_zero_a: assert property (sif.tick && state_r == ST_ANGLE
		&& !fault_in && cfg_r[CFG_SENSE] == CFG_RESET
		|=> state_r == ST_PARK)
		else $error("zero pulse length not skipped");
	ramp_zero_a: assert property (sif.tick && state_r == ST_FORCED
		&& !fault_in && cfg_r[CFG_ACCEL] == CFG_RESET
		|=> state_r == ST_RUN)
		else $error("zero ramp rate not skipped");
	out_follow_a: assert property ($changed(state_r)
		|-> sequencer_state_var == state_r)
		else $error("state output lags state");

	run_reached_c: cover property (state_r == ST_FORCED ##1 state_r == ST_RUN);
	catch_direct_c: cover property (state_r == ST_CATCH ##1 state_r == ST_RUN);
	fault_clear_c: cover property (state_r == ST_FAULT ##1 state_r == ST_STOP);
endmodule : motor_start_sequencer
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the motor start sequencer, driven over APB.
// Assumes a short tick and fault wait set below, and one APB wait state.
`default_nettype none
`define CHK(a, e) \
	begin \
		cmp_count++; \
		if ((a) !== (e)) \
		begin \
			fails++; \
			$display("Error at %0t: got %h, expected %h", $time, (a), (e)); \
		end \
	end
module tb_top
	import seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Shortened counts keep the run small
	localparam int TP = 20;
	localparam int FT = 5;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic params_valid = 1'b0;
	logic fault_in = 1'b0;
	logic offset_cal_done = 1'b0;
	logic precharge_done = 1'b0;
	logic sense_done = 1'b0;
	logic signed [15:0] measured_speed = 16'sh0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] sequencer_state_var;
	logic measure_en;
	logic offset_calibration;
	logic bootstrap_precharge;
	logic spinning_rotor_catch;
	logic align_en;
	logic forced_angle_ramp;
	logic initial_angle_detect;
	logic closed_loop_run;
	logic current_cmd_zero;
	logic [15:0] align_step;
	logic [15:0] forced_speed;
	logic [15:0] sense_pulse_length;
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;

	motor_start_sequencer #(.TICK_PERIOD(TP), .FAULT_TICKS(FT))
		motor_start_sequencer_i (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.params_valid(params_valid), .fault_in(fault_in),
		.offset_cal_done(offset_cal_done), .precharge_done(precharge_done),
		.sense_done(sense_done), .measured_speed(measured_speed),
		.sequencer_state_var(sequencer_state_var), .measure_en(measure_en),
		.offset_calibration(offset_calibration),
		.bootstrap_precharge(bootstrap_precharge),
		.spinning_rotor_catch(spinning_rotor_catch), .align_en(align_en),
		.forced_angle_ramp(forced_angle_ramp),
		.initial_angle_detect(initial_angle_detect),
		.closed_loop_run(closed_loop_run),
		.current_cmd_zero(current_cmd_zero), .align_step(align_step),
		.forced_speed(forced_speed),
		.sense_pulse_length(sense_pulse_length));

	always #2.5 clk = ~clk;

	// ==========================================================
	// Shared tasks
	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			`CHK(pready, 1'b1)
			final_report;
		end
	endtask : apb

	task automatic wreg(input logic [7:0] a, input logic [31:0] d,
		input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		`CHK(e, xe)
	endtask : wreg

	task automatic rchk(input logic [7:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		`CHK(r, x)
		`CHK(e, xe)
	endtask : rchk

	// Bounded wait on the state; cyc keeps the cycles spent waiting
	task automatic wait_st(input logic [3:0] s, input int lim = 3 * TP);
		int n;
		n = 0;
		while (sequencer_state_var !== s && n < lim)
		begin
			@(posedge clk);
			n++;
		end
		cyc = n;
		`CHK(sequencer_state_var, s)
		if (sequencer_state_var !== s)
			final_report;
	endtask : wait_st

	task automatic cfg(input logic [15:0] v [CFG_NUM]);
		for (int i = 0; i < CFG_NUM; i++)
			wreg(CFG_BASE_ADDR + 8'(4 * i), {16'hffff, v[i]}, 1'b0);
	endtask : cfg

	task automatic launch;
		wreg(CTRL_ADDR, 32'h1, 1'b0);
		wait_st(ST_PRECHARGE);
		`CHK(bootstrap_precharge, 1'b1)
		@(posedge clk);
		precharge_done <= 1'b1;
		@(posedge clk);
		precharge_done <= 1'b0;
		wait_st(ST_CATCH);
	endtask : launch

	task automatic halt;
		wreg(CTRL_ADDR, 32'h2, 1'b0);
		wait_st(ST_STOP);
	endtask : halt

	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK(sequencer_state_var, 4'h0)
		`CHK(current_cmd_zero, 1'b1)
		rchk(CTRL_ADDR, 32'h0, 1'b0);
		for (int i = 0; i < CFG_NUM; i++)
			rchk(CFG_BASE_ADDR + 8'(4 * i), 32'h0, 1'b0);
		rchk(8'h40, 32'h0, 1'b1);
		wreg(STATUS_ADDR, 32'h0, 1'b1);
		repeat (3 * TP) @(posedge clk);
		`CHK(sequencer_state_var, 4'h0)
		params_valid <= 1'b1;
		wait_st(ST_STOP);
		`CHK(measure_en, 1'b1)
		wait_st(ST_OFFSET_CAL);
		`CHK(cyc, TP)
		`CHK(offset_calibration, 1'b1)
		@(posedge clk);
		offset_cal_done <= 1'b1;
		@(posedge clk);
		offset_cal_done <= 1'b0;
		wait_st(ST_STOP);
		repeat (2 * TP) @(posedge clk);
		rchk(STATUS_ADDR, 32'h11, 1'b0);
		// All settings zero: every skip path in turn
		launch;
		wait_st(ST_ANGLE);
		wait_st(ST_PARK);
		wait_st(ST_FORCED);
		wait_st(ST_RUN);
		`CHK(closed_loop_run, 1'b1)
		`CHK(current_cmd_zero, 1'b0)
		halt;
		// Fast negative spin caught straight into run
		cfg('{16'h0003, 16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0000});
		rchk(CFG_BASE_ADDR + 8'h10, 32'h64, 1'b0);
		measured_speed <= -16'sd200;
		launch;
		`CHK(spinning_rotor_catch, 1'b1)
		`CHK(current_cmd_zero, 1'b1)
		wait_st(ST_RUN, 6 * TP);
		halt;
		// Speed equal to the limit is not above it
		measured_speed <= 16'sd100;
		cfg('{16'h0001, 16'h0002, 16'h000a, 16'h0000, 16'h0064, 16'h001e});
		launch;
		wait_st(ST_ANGLE);
		wait_st(ST_PARK);
		`CHK(align_en, 1'b1)
		repeat (TP + 1) @(posedge clk);
		`CHK(align_step, 16'h0001)
		wait_st(ST_FORCED, 5 * TP);
		`CHK(forced_angle_ramp, 1'b1)
		`CHK(forced_speed, 16'h0000)
		repeat (TP + 1) @(posedge clk);
		`CHK(forced_speed, 16'h000a)
		wait_st(ST_RUN, 6 * TP);
		halt;
		// Angle sensing with pulses waits for its done
		cfg('{16'h0000, 16'h0000, 16'h0000, 16'h0004, 16'h0064, 16'h001e});
		launch;
		wait_st(ST_ANGLE);
		`CHK(sense_pulse_length, 16'h0004)
		repeat (2 * TP) @(posedge clk);
		`CHK(sequencer_state_var, 4'h9)
		`CHK(initial_angle_detect, 1'b1)
		@(posedge clk);
		sense_done <= 1'b1;
		@(posedge clk);
		sense_done <= 1'b0;
		wait_st(ST_RUN);
		// Fault in run, timed exit outside serial mode
		fault_in <= 1'b1;
		wait_st(ST_FAULT);
		`CHK(closed_loop_run, 1'b0)
		fault_in <= 1'b0;
		wait_st(ST_STOP, (FT + 2) * TP);
		`CHK(cyc, FT * TP)
		// Serial mode: fault beats a start, then needs the acknowledge
		wreg(CTRL_ADDR, 32'h4, 1'b0);
		fault_in <= 1'b1;
		wreg(CTRL_ADDR, 32'h5, 1'b0);
		wait_st(ST_FAULT);
		fault_in <= 1'b0;
		repeat ((FT + 2) * TP) @(posedge clk);
		`CHK(sequencer_state_var, 4'h5)
		wreg(FAULT_ACK_ADDR, 32'h1, 1'b0);
		wait_st(ST_STOP);
		rchk(FAULT_ACK_ADDR, 32'h0, 1'b0);
		final_report;
	end
endmodule : tb_top
`default_nettype wire
